//--- hdl/cip_regs.sv
// Part information and temperature profile register bank of the charger
//
// Contract
// [R01] Writing one to reset request restores all registers and restarts the safety timer; code clears wdog_fault, not set as at reset.
// [R02] Reset request bit clears itself by hardware after the reset completes.
// [R03] Writing zero to reset request changes nothing; bit resets to zero.
// [R04] Part number and reserved identification bits are read-only, writes ignored.
// [R05] Cool scale codes: none, fifth (default), half, full charge current.
// [R06] Full-current scale code means the safety timer is not doubled.
// [R07] Warm scale uses same codes, defaults to full current.
// [R08] Warm threshold codes 48.25, 44.75 (default), 40.75, 37.75 percent.
// [R09] Temperature profile register at 0Ch reads 75h after reset.
// [R10] Temperature profile returns to defaults on reset request or watchdog expiry.
// [R11] Watchdog expiry sets the watchdog fault flag and selects default mode.
`timescale 1ns/1ps
`default_nettype none
module cip_regs
    import cip_pkg::*;
#(
    parameter logic [3:0] PART_NUMBER = CIP_PART_NUMBER_DEF // Arbitrary value
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire cip_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic wdog_expire,
    output logic wdog_fault,
    output logic host_mode,
    output logic safety_timer_restart,
    output cip_temp_profile_s temp_profile,
    output cip_pct_e cool_current_pct,
    output cip_pct_e warm_current_pct,
    output logic cool_timer_double,
    output logic warm_timer_double
);

    // ****************************************
    // Register write decode
    // ****************************************
    logic wr_id;
    logic wr_tp;
    logic rst_req_r;
    logic [7:0] tp_r;
    logic [7:0] tp_nxt;
    logic wdog_fault_nxt;
    cip_temp_profile_s tp_nxt_fields;

    // Field view of the profile reset value, used by the registered decodes
    localparam cip_temp_profile_s TP_RST_FIELDS = cip_temp_profile_s'(CIP_TEMP_PROFILE_RST);

    assign wr_id = reg_req.wr && reg_req.addr == CIP_ADDR_PART_INFO;
    assign wr_tp = reg_req.wr && reg_req.addr == CIP_ADDR_TEMP_PROFILE;

    // Share of the programmed fast charge current for one zone code
    function automatic cip_pct_e scale_pct(input logic [1:0] code);
        unique case (code)
            CIP_SCALE_NONE: scale_pct = CIP_PCT_0;
            CIP_SCALE_FIFTH: scale_pct = CIP_PCT_20;
            CIP_SCALE_HALF: scale_pct = CIP_PCT_50;
            CIP_SCALE_FULL: scale_pct = CIP_PCT_100;
        endcase
    endfunction

    // Reduced zone current lets the safety timer run at double length
    function automatic logic timer_doubles(input logic [1:0] code);
        timer_doubles = code != CIP_SCALE_FULL;
    endfunction

    // ****************************************
    // Reset request bit
    // ****************************************
    // Held one cycle: the register restore completes on the following edge
    // A new request in that cycle wins and holds the bit for one more restore
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rst_req_r <= 1'b0; // R03
        end else begin
            rst_req_r <= wr_id && reg_req.wdata[CIP_RST_REQ_BIT]; // R01 R02 R03
        end
    end

    assign safety_timer_restart = rst_req_r; // R01

    a_rst_req_set: assert property (@(posedge core_clk) disable iff (!rst_b) // R01
        wr_id && reg_req.wdata[CIP_RST_REQ_BIT] |=> rst_req_r ##1 tp_r == CIP_TEMP_PROFILE_RST)
        else $error("reset request did not restore profile");
    a_rst_req_self_clear: assert property (@(posedge core_clk) disable iff (!rst_b) // R02
        rst_req_r && !(wr_id && reg_req.wdata[CIP_RST_REQ_BIT]) |=> !rst_req_r)
        else $error("reset request did not clear");
    a_restart_cause: assert property (@(posedge core_clk) disable iff (!rst_b) // R01
        safety_timer_restart |-> $past(wr_id && reg_req.wdata[CIP_RST_REQ_BIT]))
        else $error("safety timer restart without request");
    a_zero_write_keep: assert property (@(posedge core_clk) disable iff (!rst_b) // R03
        wr_id && !reg_req.wdata[CIP_RST_REQ_BIT] && !rst_req_r && !wdog_expire && !wr_tp |=> $stable(tp_r))
        else $error("zero write changed profile");

    // ****************************************
    // Temperature profile register
    // ****************************************
    // A restore wins over a host write in the same cycle
    always_comb begin
        tp_nxt = tp_r;
        if (rst_req_r || wdog_expire) begin
            tp_nxt = CIP_TEMP_PROFILE_RST; // R01 R10
        end else if (wr_tp) begin
            tp_nxt = reg_req.wdata; // R05 R07 R08
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tp_r <= CIP_TEMP_PROFILE_RST; // R09
        end else begin
            tp_r <= tp_nxt;
        end
    end

    assign tp_nxt_fields = cip_temp_profile_s'(tp_nxt);
    assign temp_profile = cip_temp_profile_s'(tp_r); // R08

    a_profile_write: assert property (@(posedge core_clk) disable iff (!rst_b) // R08
        wr_tp && !rst_req_r && !wdog_expire |=> tp_r == $past(reg_req.wdata))
        else $error("profile write not stored");
    a_reset_value: assert property (@(posedge core_clk) // R09
        !rst_b |=> tp_r == CIP_TEMP_PROFILE_RST && wdog_fault) else $error("profile reset value wrong");
    a_wdog_default: assert property (@(posedge core_clk) disable iff (!rst_b) // R10
        wdog_expire |=> tp_r == CIP_TEMP_PROFILE_RST && wdog_fault && !host_mode) else $error("watchdog restore failed");

    // ****************************************
    // Zone current and timer decodes
    // ****************************************
    // Decoded from the next profile so they change on the same edge as the register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cool_current_pct <= scale_pct(TP_RST_FIELDS.cool_zone_current_scale); // R05
            warm_current_pct <= scale_pct(TP_RST_FIELDS.warm_zone_current_scale); // R07
            cool_timer_double <= timer_doubles(TP_RST_FIELDS.cool_zone_current_scale); // R06
            warm_timer_double <= timer_doubles(TP_RST_FIELDS.warm_zone_current_scale); // R06
        end else begin
            cool_current_pct <= scale_pct(tp_nxt_fields.cool_zone_current_scale); // R05
            warm_current_pct <= scale_pct(tp_nxt_fields.warm_zone_current_scale); // R07
            cool_timer_double <= timer_doubles(tp_nxt_fields.cool_zone_current_scale); // R06
            warm_timer_double <= timer_doubles(tp_nxt_fields.warm_zone_current_scale); // R06
        end
    end

    a_scale_map: assert property (@(posedge core_clk) disable iff (!rst_b) // R05
        temp_profile.cool_zone_current_scale == CIP_SCALE_FIFTH |-> cool_current_pct == CIP_PCT_20)
        else $error("cool scale mapping wrong");
    a_warm_scale_map: assert property (@(posedge core_clk) disable iff (!rst_b) // R07
        temp_profile.warm_zone_current_scale == CIP_SCALE_HALF |-> warm_current_pct == CIP_PCT_50)
        else $error("warm scale mapping wrong");
    a_timer_no_double: assert property (@(posedge core_clk) disable iff (!rst_b) // R06
        temp_profile.warm_zone_current_scale == CIP_SCALE_FULL |-> !warm_timer_double && warm_current_pct == CIP_PCT_100)
        else $error("timer doubled at full current");
    a_cool_no_double: assert property (@(posedge core_clk) disable iff (!rst_b) // R06
        temp_profile.cool_zone_current_scale == CIP_SCALE_FULL |-> !cool_timer_double && cool_current_pct == CIP_PCT_100)
        else $error("cool timer doubled at full current");

    // ****************************************
    // Watchdog fault flag and mode
    // ****************************************
    // Flag powers up set; a register reset request returns it to host mode
    // Expiry wins over a clear in the same cycle
    always_comb begin
        wdog_fault_nxt = wdog_fault;
        if (wdog_expire) begin
            wdog_fault_nxt = 1'b1; // R11
        end else if (rst_req_r || wr_tp) begin
            wdog_fault_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wdog_fault <= 1'b1;
            host_mode <= 1'b0;
        end else begin
            wdog_fault <= wdog_fault_nxt; // R11
            host_mode <= !wdog_fault_nxt; // R11
        end
    end

    a_mode_pair: assert property (@(posedge core_clk) disable iff (!rst_b) // R11
        host_mode != wdog_fault) else $error("host mode and fault flag disagree");
    a_fault_clear: assert property (@(posedge core_clk) disable iff (!rst_b) // R11
        (rst_req_r || wr_tp) && !wdog_expire |=> !wdog_fault && host_mode)
        else $error("fault flag did not clear");

    // ****************************************
    // Read data
    // ****************************************
    // Data follows the address of every cycle; only a valid answer counts
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.addr == CIP_ADDR_PART_INFO) begin
                reg_rdata <= {rst_req_r, PART_NUMBER, CIP_ID_RESERVED_VAL}; // R04
            end else if (reg_req.addr == CIP_ADDR_TEMP_PROFILE) begin
                reg_rdata <= tp_r;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    a_id_readonly: assert property (@(posedge core_clk) disable iff (!rst_b) // R04
        reg_rvalid && $past(reg_req.addr) == CIP_ADDR_PART_INFO
        |-> reg_rdata[6:0] == {PART_NUMBER, CIP_ID_RESERVED_VAL})
        else $error("identification bits changed");

    // ****************************************
    // Coverage
    // ****************************************
    // Main scenarios: restore request, host write, expiry, full current in both zones
    c_reset_request: cover property (@(posedge core_clk) rst_req_r);
    c_profile_write: cover property (@(posedge core_clk) wr_tp ##1 tp_r != CIP_TEMP_PROFILE_RST);
    c_wdog_expire: cover property (@(posedge core_clk) !wdog_fault ##1 wdog_expire);
    c_full_current: cover property (@(posedge core_clk) !cool_timer_double && !warm_timer_double);
endmodule // cip_regs
`default_nettype wire

//--- hdl/cip_pkg.sv
// Package of register map, field layout and reset values for the charger id and temperature profile registers
`default_nettype none
package cip_pkg;
    localparam logic [7:0] CIP_ADDR_PART_INFO = 8'h0B;
    localparam logic [7:0] CIP_ADDR_TEMP_PROFILE = 8'h0C;
    localparam int CIP_RST_REQ_BIT = 7;
    localparam logic [3:0] CIP_PART_NUMBER_DEF = 4'h3; // Arbitrary value
    localparam logic [2:0] CIP_ID_RESERVED_VAL = 3'h4;
    localparam logic [7:0] CIP_TEMP_PROFILE_RST = 8'h75;
    localparam logic [1:0] CIP_SCALE_NONE = 2'h0;
    localparam logic [1:0] CIP_SCALE_FIFTH = 2'h1;
    localparam logic [1:0] CIP_SCALE_HALF = 2'h2;
    localparam logic [1:0] CIP_SCALE_FULL = 2'h3;
    localparam logic [1:0] CIP_WARM_THR_4825 = 2'h0;
    localparam logic [1:0] CIP_WARM_THR_4475 = 2'h1;
    localparam logic [1:0] CIP_WARM_THR_4075 = 2'h2;
    localparam logic [1:0] CIP_WARM_THR_3775 = 2'h3;

    typedef struct packed {
        logic [1:0] cool_zone_current_scale;
        logic [1:0] warm_zone_current_scale;
        logic [1:0] cool_threshold_select;
        logic [1:0] warm_threshold_select;
    } cip_temp_profile_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cip_reg_req_s;

    typedef enum logic [1:0] {
        CIP_PCT_0,
        CIP_PCT_20,
        CIP_PCT_50,
        CIP_PCT_100
    } cip_pct_e;
endpackage
`default_nettype wire

//--- bench/cip_host.sv
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
`default_nettype none
module cip_host
    import cip_pkg::*;
(
    input wire logic core_clk,
    output cip_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial reg_req = '0;
    // Released address and data show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_req <= {1'b1, 1'b0, a, d};
        @(negedge core_clk);
        reg_req <= {1'b0, 1'b0, ~a, ~d};
    endtask
    // Answer is due the cycle after the read is taken
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge core_clk);
        reg_req <= {1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk);
        reg_req <= {1'b0, 1'b0, ~a, 8'hFF};
        ok = (reg_rvalid === 1'b1);
        d = reg_rdata;
    endtask
endmodule // cip_host
`default_nettype wire

//--- bench/tb_cip_regs.sv
// Self-checking testbench of the register bank
`timescale 1ns/1ps
`default_nettype none
module tb_cip_regs;
    import cip_pkg::*;
    localparam logic [7:0] ID = {1'b0, CIP_PART_NUMBER_DEF, CIP_ID_RESERVED_VAL};
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wdog_expire = 1'b0;
    cip_reg_req_s reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid, wdog_fault, host_mode, safety_timer_restart, cool_timer_double, warm_timer_double;
    cip_temp_profile_s temp_profile;
    cip_pct_e cool_current_pct, warm_current_pct;
    int n_fail = 0;
    int num_checks = 0;
    logic [7:0] v;
    cip_regs i_cip_regs (.core_clk, .rst_b, .reg_req, .reg_rdata, .reg_rvalid, .wdog_expire, .wdog_fault,
        .host_mode, .safety_timer_restart, .temp_profile, .cool_current_pct, .warm_current_pct,
        .cool_timer_double, .warm_timer_double);
    cip_host i_cip_host (.core_clk, .reg_req, .reg_rdata, .reg_rvalid);
    initial forever #5 core_clk = ~core_clk;
    function automatic cip_pct_e pct(input logic [1:0] c);
        return c == CIP_SCALE_NONE ? CIP_PCT_0 : c == CIP_SCALE_FIFTH ? CIP_PCT_20 :
            c == CIP_SCALE_HALF ? CIP_PCT_50 : CIP_PCT_100;
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkp(input logic [7:0] e);
        chk("profile", e, temp_profile);
        chk("cool pct", {6'h0, pct(e[7:6])}, {6'h0, cool_current_pct});
        chk("warm pct", {6'h0, pct(e[5:4])}, {6'h0, warm_current_pct});
        chk("double", {6'h0, e[7:6] != CIP_SCALE_FULL, e[5:4] != CIP_SCALE_FULL},
            {6'h0, cool_timer_double, warm_timer_double});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        logic ok;
        i_cip_host.rd(a, d, ok);
        chk("rvalid", 8'h01, {7'h0, ok});
        chk(nm, e, d);
        if (!ok) results();
    endtask
    initial begin
        void'($urandom(48114));
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        chkp(CIP_TEMP_PROFILE_RST);
        chk("mode", 8'h02, {6'h0, wdog_fault, host_mode});
        rdc(CIP_ADDR_PART_INFO, ID, "id");
        rdc(CIP_ADDR_TEMP_PROFILE, CIP_TEMP_PROFILE_RST, "prof");
        for (int i = 0; i < 12; i++) begin
            v = (i < 4) ? {4{2'(i)}} : 8'($urandom);
            i_cip_host.wr(CIP_ADDR_TEMP_PROFILE, v);
            chkp(v);
            rdc(CIP_ADDR_TEMP_PROFILE, v, "prof rw");
        end
        i_cip_host.wr(CIP_ADDR_TEMP_PROFILE, 8'h8A);
        i_cip_host.wr(CIP_ADDR_PART_INFO, 8'h7F);
        chk("restart", 8'h00, {7'h0, safety_timer_restart});
        i_cip_host.wr(8'h0D, 8'hA5);
        rdc(CIP_ADDR_PART_INFO, ID, "id ro");
        rdc(8'h0D, 8'h00, "unmapped");
        rdc(CIP_ADDR_TEMP_PROFILE, 8'h8A, "kept");
        i_cip_host.wr(CIP_ADDR_PART_INFO, 8'h80);
        chk("restart", 8'h01, {7'h0, safety_timer_restart});
        @(negedge core_clk);
        chk("restart", 8'h00, {7'h0, safety_timer_restart});
        chkp(CIP_TEMP_PROFILE_RST);
        rdc(CIP_ADDR_PART_INFO, ID, "self clear");
        i_cip_host.wr(CIP_ADDR_TEMP_PROFILE, 8'hCE);
        chk("mode", 8'h01, {6'h0, wdog_fault, host_mode});
        wdog_expire = 1'b1;
        @(negedge core_clk);
        wdog_expire = 1'b0;
        chkp(CIP_TEMP_PROFILE_RST);
        chk("mode", 8'h02, {6'h0, wdog_fault, host_mode});
        i_cip_host.wr(CIP_ADDR_TEMP_PROFILE, 8'h3A);
        chkp(8'h3A);
        chk("mode", 8'h01, {6'h0, wdog_fault, host_mode});
        rst_b = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        chkp(CIP_TEMP_PROFILE_RST);
        chk("mode", 8'h02, {6'h0, wdog_fault, host_mode});
        rdc(CIP_ADDR_TEMP_PROFILE, CIP_TEMP_PROFILE_RST, "prof after reset");
        results();
    end
endmodule // tb_cip_regs
`default_nettype wire
